/* File: wdtu_consts.svh */
// Purpose: Offsets, fields, resets and counts of the watchdog unit.
// Assumes: Included by the top module only.
// Notes: Definitions only.
//
// Notes on behaviour
// RL1 - Every reset leaves the watchdog not counting.
// RL2 - Writing 1 to the enable bit starts it; only a reset stops it.
// RL3 - Period code 00/01/10/11 selects 2^27/2^25/2^22/2^18 counts.
// RL4 - Clock select 00 counts system clocks, 01 real-time ticks.
// RL5 - Every expiry sets the read-only timeout flag at bit 5.
// RL6 - The flag survives a watchdog reset; only chip reset clears it.
// RL7 - Bit 6 picks the expiry response: 0 resets the CPU, 1 raises NMI.
// RL8 - The reset or NMI output changes only on a rising clock edge.
// RL9 - Writing A5h then 5Ah to the restart register restarts the count.
// RL10 - Any delay between the two writes is allowed unless expiry comes.
// RL11 - The restart register is 8-bit write-only and reads nothing.
// RL12 - Control is 8-bit; bits 5 and 2 read-only, bit 2 reads 0.
// RL13 - Software picks a period long enough for flash operations.
// RL14 - A restart write out of order discards the partial sequence.
`ifndef WDTU_CONSTS_SVH
`define WDTU_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define WDTU_ADR_CTL 8'h93
`define WDTU_ADR_RR  8'h94
`define WDTU_ADR_STS 8'h95
`define WDTU_ADR_MSK 8'h96

// ----------------------------------------
// Control fields and restart keys
// ----------------------------------------
`define WDTU_B_EN    7
`define WDTU_B_NMI   6
`define WDTU_B_FLAG  5
`define WDTU_CLK_SYS 2'h0
`define WDTU_CLK_RTC 2'h1
`define WDTU_KEY1    8'hA5
`define WDTU_KEY2    8'h5A
`define WDTU_CTL_RST 8'h00

// ----------------------------------------
// Expiry counts
// ----------------------------------------
`define WDTU_PER00 134217728
`define WDTU_PER01 33554432
`define WDTU_PER10 4194304
`define WDTU_PER11 262144

`endif

/* File: wdtu_pkg.sv */
// Purpose: Types of the watchdog unit.
// Assumes: Nothing beyond the language.
// Notes: One packed struct carries all state.
package wdtu_pkg;

    // Restart key sequence.
    typedef enum logic [0:0] {
        SEQ_IDLE,
        SEQ_ARMED
    } wdtu_seq_e;

    typedef struct packed {
        logic        en;
        logic        nmi_sel;
        logic [1:0]  clk_sel;
        logic [1:0]  period;
        logic        flag;
        logic [26:0] cnt;
        wdtu_seq_e   seq;
        logic [2:0]  sts;
        logic [2:0]  msk;
        logic [7:0]  rdata;
        logic        rst_o;
        logic        nmi_o;
        logic        irq;
    } wdtu_state_s;

endpackage : wdtu_pkg

/* File: wdtu_top.sv */
// Purpose: Watchdog unit with selectable period, source and response.
// Assumes: All inputs synchronous to clk; arst_n is the chip reset.
// Notes: Outputs all come from flip-flops of one state struct.
`timescale 1ns/10ps
`include "wdtu_consts.svh"

module wdtu_top #(
    parameter int unsigned PER00 = `WDTU_PER00, // Count for code 00.
    parameter int unsigned PER01 = `WDTU_PER01, // Count for code 01.
    parameter int unsigned PER10 = `WDTU_PER10, // Count for code 10.
    parameter int unsigned PER11 = `WDTU_PER11  // Count for code 11.
) (
    input  wire logic       clk,      // System clock, 100 MHz.
    input  wire logic       arst_n,   // Chip reset, active low.
    input  wire logic [7:0] addr,     // Register address.
    input  wire logic [7:0] wdata,    // Write data.
    input  wire logic       wr,       // Write strobe.
    input  wire logic       rd,       // Read strobe.
    input  wire logic       rtc_tick, // Real-time source tick.
    output logic      [7:0] rdata,    // Read data, cycle after rd.
    output logic            cpu_rst,  // CPU reset pulse.
    output logic            nmi,      // NMI pulse.
    output logic            irq       // Level interrupt.
);

    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    // The counter is 27 bits wide, so no period may exceed 2^27.
    if (PER00 < 2 || PER00 > `WDTU_PER00 || PER01 < 2 ||
        PER01 > `WDTU_PER00 || PER10 < 2 || PER10 > `WDTU_PER00 ||
        PER11 < 2 || PER11 > `WDTU_PER00) begin : g_bad_period
        $error("wdtu_top: period out of range");
    end

    wdtu_pkg::wdtu_state_s s_r;
    wdtu_pkg::wdtu_state_s s_nxt;
    logic [26:0]           lim_m1;
    logic                  tick;
    logic                  expire;
    logic                  wr_ctl;
    logic                  wr_rr;
    logic                  rstrt;
    logic                  bad;

    // ----------------------------------------
    // Counting
    // ----------------------------------------
    // Period code to last count value.
    always_comb begin
        case (s_r.period) // RL3
            2'h0:    lim_m1 = 27'(PER00 - 1);
            2'h1:    lim_m1 = 27'(PER01 - 1);
            2'h2:    lim_m1 = 27'(PER10 - 1);
            default: lim_m1 = 27'(PER11 - 1);
        endcase
    end

    // Reserved source codes never tick, so a bad code only stalls.
    assign tick   = s_r.en && ((s_r.clk_sel == `WDTU_CLK_SYS) ||
                    (s_r.clk_sel == `WDTU_CLK_RTC && rtc_tick)); // RL4
    // A shortened period may leave the count above the new limit; the
    // next tick then expires at once instead of running round 2^27.
    assign expire = tick && (s_r.cnt >= lim_m1); // RL3
    assign wr_ctl = wr && (addr == `WDTU_ADR_CTL);
    assign wr_rr  = wr && (addr == `WDTU_ADR_RR);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_nxt       = s_r;
        s_nxt.rdata = 8'h00;
        s_nxt.rst_o = 1'b0;
        s_nxt.nmi_o = 1'b0;
        rstrt       = 1'b0;
        bad         = 1'b0;
        if (tick) begin
            s_nxt.cnt = s_r.cnt + 27'h0000001;
        end
        // Enable is sticky: a written 0 is ignored.
        if (wr_ctl) begin
            s_nxt.en      = s_r.en | wdata[`WDTU_B_EN]; // RL2
            s_nxt.nmi_sel = wdata[`WDTU_B_NMI];
            s_nxt.clk_sel = wdata[4:3];
            s_nxt.period  = wdata[1:0];
        end
        if (wr && addr == `WDTU_ADR_MSK) begin
            s_nxt.msk = wdata[2:0];
        end
        // Restart keys; the register holds nothing readable.
        if (wr_rr) begin // RL11
            if (wdata == `WDTU_KEY1) begin
                s_nxt.seq = wdtu_pkg::SEQ_ARMED; // RL10
            end else if (wdata == `WDTU_KEY2 &&
                         s_r.seq == wdtu_pkg::SEQ_ARMED) begin
                s_nxt.seq = wdtu_pkg::SEQ_IDLE;
                s_nxt.cnt = 27'h0000000; // RL9
                rstrt     = 1'b1;
            end else begin
                s_nxt.seq = wdtu_pkg::SEQ_IDLE; // RL14
                bad       = 1'b1;
            end
        end
        if (rd) begin
            case (addr)
                `WDTU_ADR_CTL: s_nxt.rdata = {s_r.en, s_r.nmi_sel, s_r.flag,
                               s_r.clk_sel, 1'b0, s_r.period}; // RL12
                `WDTU_ADR_STS: begin
                    s_nxt.rdata = {5'h00, s_r.sts};
                    s_nxt.sts   = 3'h0;
                end
                `WDTU_ADR_MSK: s_nxt.rdata = {5'h00, s_r.msk};
                default:       s_nxt.rdata = 8'h00;
            endcase
        end
        // Expiry beats a second key in the same cycle.
        if (expire) begin
            s_nxt.flag = 1'b1; // RL5
            s_nxt.seq  = wdtu_pkg::SEQ_IDLE; // RL10
            s_nxt.cnt  = 27'h0000000;
            rstrt      = 1'b0;
            if (s_r.nmi_sel) begin
                s_nxt.nmi_o = 1'b1; // RL7
            end else begin
                // Own reset clears control but keeps the flag.
                s_nxt.rst_o   = 1'b1; // RL7
                s_nxt.en      = 1'b0; // RL1
                s_nxt.nmi_sel = 1'b0;
                s_nxt.clk_sel = 2'h0;
                s_nxt.period  = 2'h0;
            end
        end
        // Sets come after the read clear so an event is never lost.
        s_nxt.sts = s_nxt.sts | {bad, rstrt, expire};
        s_nxt.irq = |(s_nxt.sts & s_nxt.msk);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    // Chip reset is the only path that clears the flag.
    always_ff @(posedge clk or negedge arst_n) begin // RL8
        if (!arst_n) begin
            s_r <= '0; // RL1 RL6
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata   = s_r.rdata;
    assign cpu_rst = s_r.rst_o;
    assign nmi     = s_r.nmi_o;
    assign irq     = s_r.irq;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_rst_dis;
        @(posedge clk) disable iff (!arst_n) s_r.rst_o |-> !s_r.en;
    endproperty
    a_rst_dis: assert property (p_rst_dis) else $error("enabled after reset"); // RL1

    property p_en_hold;
        @(posedge clk) disable iff (!arst_n)
            s_r.en && !(expire && !s_r.nmi_sel) |=> s_r.en;
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable dropped"); // RL2

    property p_cnt_lim;
        @(posedge clk) disable iff (!arst_n) tick && !wr_ctl |=> s_r.cnt <= lim_m1;
    endproperty
    a_cnt_lim: assert property (p_cnt_lim) else $error("count past period"); // RL3

    property p_sys_cnt;
        @(posedge clk) disable iff (!arst_n)
            s_r.en && s_r.clk_sel == 2'h0 && !expire && !rstrt
            |=> s_r.cnt == $past(s_r.cnt) + 27'h0000001;
    endproperty
    a_sys_cnt: assert property (p_sys_cnt) else $error("no system count"); // RL4

    property p_flag_set;
        @(posedge clk) disable iff (!arst_n) expire |=> s_r.flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set"); // RL5

    property p_flag_keep;
        @(posedge clk) disable iff (!arst_n) s_r.flag |=> s_r.flag ##1 s_r.flag;
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag lost"); // RL6

    property p_resp;
        @(posedge clk) disable iff (!arst_n)
            expire |=> (s_r.nmi_o == $past(s_r.nmi_sel)) && (s_r.rst_o != s_r.nmi_o);
    endproperty
    a_resp: assert property (p_resp) else $error("wrong response"); // RL7

    property p_out_cause;
        @(posedge clk) disable iff (!arst_n)
            (s_r.nmi_o || s_r.rst_o) |-> $past(expire);
    endproperty
    a_out_cause: assert property (p_out_cause) else $error("stray output"); // RL8

    property p_restart;
        @(posedge clk) disable iff (!arst_n)
            wr_rr && wdata == 8'h5A && s_r.seq == wdtu_pkg::SEQ_ARMED && !expire
            |=> s_r.cnt == 27'h0000000 && s_r.sts[1];
    endproperty
    a_restart: assert property (p_restart) else $error("no restart"); // RL9

    property p_arm_hold;
        @(posedge clk) disable iff (!arst_n)
            s_r.seq == wdtu_pkg::SEQ_ARMED && !wr_rr && !expire
            |=> s_r.seq == wdtu_pkg::SEQ_ARMED;
    endproperty
    a_arm_hold: assert property (p_arm_hold) else $error("arm lost"); // RL10

    property p_bad_seq;
        @(posedge clk) disable iff (!arst_n)
            wr_rr && wdata != 8'hA5 && wdata != 8'h5A
            |=> s_r.seq == wdtu_pkg::SEQ_IDLE;
    endproperty
    a_bad_seq: assert property (p_bad_seq) else $error("bad key kept"); // RL14

    property p_rd_ctl;
        @(posedge clk) disable iff (!arst_n)
            rd && addr == 8'h93 |=> !rdata[2] && rdata[5] == $past(s_r.flag);
    endproperty
    a_rd_ctl: assert property (p_rd_ctl) else $error("bad control read"); // RL12

    property p_rd_rr;
        @(posedge clk) disable iff (!arst_n) rd && addr == 8'h94 |=> rdata == 8'h00;
    endproperty
    a_rd_rr: assert property (p_rd_rr) else $error("restart reg read"); // RL11

    c_rst:  cover property (@(posedge clk) disable iff (!arst_n) s_r.rst_o);
    c_nmi:  cover property (@(posedge clk) disable iff (!arst_n) s_r.nmi_o);
    c_rstr: cover property (@(posedge clk) disable iff (!arst_n) rstrt && s_r.en);
    c_irq:  cover property (@(posedge clk) disable iff (!arst_n) s_r.irq);

endmodule // wdtu_top

/* File: wdtu_cpu_model.sv */
// Purpose: CPU side of the watchdog unit, counting reset and NMI requests.
// Assumes: Each request is a one-cycle pulse launched at a rising edge.
// Notes: gap holds the cycles between the last two NMI pulses.
`timescale 1ns/10ps
module wdtu_cpu_model (
    input  wire logic clk,     // System clock.
    input  wire logic cpu_rst, // Reset request.
    input  wire logic nmi,     // NMI request.
    output int        n_rst,   // Reset requests taken.
    output int        n_nmi,   // NMIs taken.
    output int        gap      // Cycles between NMIs.
);
    int age;
    // The CPU takes requests only at rising edges, so a glitch between edges is unseen.
    always @(posedge clk) begin
        age <= age + 1;
        if (cpu_rst === 1'b1) begin
            n_rst <= n_rst + 1;
        end
        if (nmi === 1'b1) begin
            n_nmi <= n_nmi + 1;
            gap   <= age;
            age   <= 1;
        end
    end
endmodule // wdtu_cpu_model

/* File: wdtu_top_tb.sv */
// Purpose: Self-checking bench of the watchdog unit.
// Assumes: Periods 64/48/32/16 stand in for the long counts.
// Notes: Expected register values come from an integer model.
`timescale 1ns/10ps
module wdtu_top_tb;
    localparam int LIMIT = 6000; // Cycle ceiling.
    int         per [4] = '{64, 48, 32, 16};
    logic       clk, arst_n, wr, rd, rtc_tick, tick_en, cpu_rst, nmi, irq;
    logic [7:0] addr, wdata, rdata, v;
    int         n_rst, n_nmi, gap, n0, ticks, cycles, m_ctl, errors, total_checks;
    integer     seed = 32'hb81b;

    wdtu_top #(.PER00(64), .PER01(48), .PER10(32), .PER11(16)) i_wdtu_top (
        .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rtc_tick(rtc_tick), .rdata(rdata), .cpu_rst(cpu_rst),
        .nmi(nmi), .irq(irq));
    wdtu_cpu_model i_wdtu_cpu_model (.clk(clk), .cpu_rst(cpu_rst), .nmi(nmi),
        .n_rst(n_rst), .n_nmi(n_nmi), .gap(gap));

    // -------------------------
    // Clock, ticks and timeout
    // -------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Random ticks keep the count from riding a fixed pattern.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (rtc_tick) begin
            ticks <= ticks + 1;
        end
        rtc_tick <= tick_en && ($random(seed) & 1);
        if (cycles == LIMIT) begin
            errors++;
            finish_test();
        end
    end

    // -------------------------
    // Tasks
    // -------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // A cycle of idle follows each strobe so no strobe is assigned twice at one edge.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    task automatic ctl_w(input logic [7:0] d);
        wr_reg(8'h93, d);
        m_ctl = (d & 8'hDB) | (m_ctl & 8'hA0);
    endtask
    task automatic restart();
        wr_reg(8'h94, 8'hA5);
        wr_reg(8'h94, 8'h5A);
    endtask
    task automatic wait_pulse(input bit r, input int t);
        for (int i = 0; i < 400 && (r ? n_rst : n_nmi) < t; i++) @(posedge clk);
    endtask
    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        m_ctl = 0;
    endtask

    // -------------------------
    // Main sequence
    // -------------------------
    initial begin
        arst_n   = 1'b0;
        addr     = 8'h00;
        wdata    = 8'h00;
        wr       = 1'b0;
        rd       = 1'b0;
        tick_en  = 1'b0;
        do_reset();
        wr_reg(8'h93, 8'h24);
        wr_reg(8'h97, 8'hFF);
        rd_reg(8'h93, v);
        chk(v, 8'h00);
        rd_reg(8'h94, v);
        chk(v, 8'h00);
        rd_reg(8'h97, v);
        chk(v, 8'h00);
        repeat (200) @(posedge clk);
        chk(8'(n_rst + n_nmi), 8'h00);
        // Every period code in NMI mode; the third pulse gives a clean interval.
        wr_reg(8'h96, 8'h01);
        for (int p = 0; p < 4; p++) begin
            restart();
            ctl_w(8'hC0 | 8'(p));
            n0 = n_nmi;
            wait_pulse(0, n0 + 3);
            chk(8'(gap == per[p]), 8'h01);
            m_ctl = m_ctl | 8'h20;
            rd_reg(8'h93, v);
            chk(v, m_ctl[7:0]);
        end
        chk(8'(n_rst), 8'h00);
        ctl_w(8'h43);
        rd_reg(8'h93, v);
        chk(v, m_ctl[7:0]);
        restart();
        rd_reg(8'h95, v);
        n0 = n_nmi;
        repeat (12) begin
            wr_reg(8'h94, 8'hA5);
            repeat ($random(seed) & 3) @(posedge clk);
            wr_reg(8'h94, 8'h5A);
        end
        chk(8'(n_nmi - n0), 8'h00);
        rd_reg(8'h95, v);
        chk(v, 8'h02);
        chk({7'h00, irq}, 8'h00);
        wr_reg(8'h96, 8'h02);
        restart();
        @(negedge clk);
        chk({7'h00, irq}, 8'h01);
        @(posedge clk);
        rd_reg(8'h95, v);
        @(negedge clk);
        chk({7'h00, irq}, 8'h00);
        @(posedge clk);
        n0 = n_nmi;
        repeat (3) begin
            wr_reg(8'h94, 8'hA5);
            wr_reg(8'h94, 8'h3C);
            wr_reg(8'h94, 8'h5A);
        end
        chk(8'(n_nmi > n0), 8'h01);
        rd_reg(8'h95, v);
        chk(v & 8'h06, 8'h04);
        // Reset response: the unit stops itself but keeps the flag.
        ctl_w(8'h03);
        n0 = n_nmi;
        wait_pulse(1, 1);
        chk(8'(n_rst), 8'h01);
        chk(8'(n_nmi - n0), 8'h00);
        repeat (3) @(posedge clk);
        m_ctl = 8'h20;
        rd_reg(8'h93, v);
        chk(v, m_ctl[7:0]);
        repeat (100) @(posedge clk);
        chk(8'(n_rst), 8'h01);
        do_reset();
        rd_reg(8'h93, v);
        chk(v, 8'h00);
        ctl_w(8'h8B);
        repeat (60) @(posedge clk);
        chk(8'(n_rst), 8'h01);
        n0 = ticks;
        tick_en = 1'b1;
        wait_pulse(1, 2);
        tick_en = 1'b0;
        chk(8'(ticks - n0 >= 16 && ticks - n0 <= 18), 8'h01);
        // A reserved source code must not count at all.
        ctl_w(8'h93);
        repeat (60) @(posedge clk);
        chk(8'(n_rst), 8'h02);
        finish_test();
    end
endmodule // wdtu_top_tb
